// [core/flash_seq_consts.svh]
// Constants for the erase/program command sequencer: opcodes, framing counts,
// self-timed durations and array layout. Included only by the erase/program sequencer module.
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OPC_WRITE_UNLOCK 8'h06
`define OPC_WIPE_4K 8'h20
`define OPC_WIPE_32K 8'h52
`define OPC_WIPE_64K 8'hD8
`define OPC_WIPE_ALL_A 8'h60
`define OPC_WIPE_ALL_B 8'hC7
`define OPC_WRITE_PAGE 8'h02

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define BYTES_OPCODE_ONLY 9'h001
`define BYTES_ADDR_FRAME 9'h005
`define BYTES_PAGE_MIN 9'h006
`define BITS_PER_BYTE 4'h8
`define ADDR_BYTES 4

// ----------------------------------------------------------------
// Self-timed durations in microseconds, and the core clock rate
// ----------------------------------------------------------------
`define CLK_MHZ 25
`define WIPE_4K_DURATION_US 40
`define WIPE_32K_DURATION_US 120
`define WIPE_64K_DURATION_US 200
`define WIPE_ALL_DURATION_US 800
`define PAGE_WRITE_DURATION_US 10

// ----------------------------------------------------------------
// Array layout
// ----------------------------------------------------------------
`define PAGE_BYTES 256
`define SECTORS_PER_BLOCK 16

`endif

// [core/flash_seq_pkg.sv]
// Types shared by the erase/program sequencer files.
// Assumes the constants header is included by each user.
package flash_seq_pkg;

  // Sequencer phase
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SCAN,
    ST_PUSH,
    ST_RUN
  } seq_state_e;

  // Size of one erase issued to the array
  typedef enum logic [1:0] {
    SPAN_4K,
    SPAN_32K,
    SPAN_64K
  } erase_span_e;

endpackage

// [core/pin_sync.sv]
// Two-flop synchroniser for a bundle of link pins.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '0 // Idle level per pin, so no false edge follows reset
) (
  input wire logic ref_clk_in, // Core clock
  input wire logic rst_in, // Async reset, high
  input wire logic [W-1:0] pin_in, // Raw pins
  output logic [W-1:0] sync_out // Synchronised copy
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ----------------------------------------------------------------
  // Two stages; only the second stage is visible
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// [core/prog_fifo.sv]
// Small synchronous FIFO between the page buffer and the array port.
// Assumes one clock; the drain side may stall for any time.
`timescale 1ns/100ps

module prog_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in, // Core clock
  input wire logic rst_in, // Async reset, high
  input wire logic in_valid_in, // Write offered
  output logic in_ready_out, // Space free
  input wire logic [W-1:0] in_data_in, // Write word
  output logic out_valid_out, // Word available
  input wire logic out_ready_in, // Drain accepts
  output logic [W-1:0] out_data_out, // Head word
  output logic empty_out // Nothing stored
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
      $error("prog_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;

  // Full and empty straight from the occupancy count
  assign in_ready_out = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != '0);
  assign empty_out = (cnt_q == '0);
  assign out_data_out = mem[rd_q];

  // ----------------------------------------------------------------
  // Pointers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cnt_q == DEPTH[AW:0] |-> !push) else $error("fifo written while full");

endmodule

// [core/flash_erase_program.sv]
// Erase and page-write command sequencer of a serial NOR flash.
// Assumes the host drives chip select, serial clock and SIO pins; the array
// sits beyond erase and program ports; lock bits arrive as static levels.
//
// Summary of operation
// - 4K command erases the addressed 4K sector
// - 32K command erases the 32K half-block chosen by address bit 15
// - 64K command erases the addressed 64K block
// - Any address in unit erases whole unit
// - Erase taken only if select rises after address
// - Opcode takes 8 SPI or 2 QPI clocks
// - Self-timed operation starts at select rising
// - Busy flag high throughout; completion clears latch
// - Busy flag readable while operation runs
// - Erase of locked unit is not carried out
// - Whole-array erase: opcode only, exact boundary
// - Range scheme: whole erase only if bits zero
// - Unit scheme: whole erase skips locked blocks
// - Page write 1 to 256 bytes, 1-to-0
// - Over 256 bytes keeps only last 256
// - Page bytes wrap inside the same page
// - Page write needs data; select rises on byte
// - Page write to locked page not done
// - Scheme select picks range or unit locks
`timescale 1ns/100ps
`include "flash_seq_consts.svh"

module flash_erase_program #(
  parameter int ADDR_W = 25,
  parameter int BLOCKS = 512,
  parameter int FIFO_DEPTH = 8,
  parameter int WIPE_4K_CYC = `WIPE_4K_DURATION_US * `CLK_MHZ,
  parameter int WIPE_32K_CYC = `WIPE_32K_DURATION_US * `CLK_MHZ,
  parameter int WIPE_64K_CYC = `WIPE_64K_DURATION_US * `CLK_MHZ,
  parameter int WIPE_ALL_CYC = `WIPE_ALL_DURATION_US * `CLK_MHZ,
  parameter int PAGE_WRITE_CYC = `PAGE_WRITE_DURATION_US * `CLK_MHZ
) (
  input wire logic ref_clk_in, // Core clock, 25 MHz
  input wire logic rst_in, // Async reset, high
  input wire logic sclk_in, // Serial clock pin
  input wire logic cs_n_in, // Chip select pin, low active
  input wire logic [3:0] sio_in, // Serial data pins
  input wire logic qpi_mode_in, // 1 = four-line commands
  input wire logic protect_scheme_select_in, // 0 range, 1 unit locks
  input wire logic [3:0] range_lock_bits_in, // Range lock level
  input wire logic [BLOCKS-1:0] persistent_unit_lock_in, // Per-block lock
  input wire logic [BLOCKS-1:0] volatile_unit_lock_in, // Per-block lock
  input wire logic [15:0] bottom_sector_lock_in, // 4K locks, block 0
  input wire logic [15:0] top_sector_lock_in, // 4K locks, last block
  output logic op_in_flight_flag_out, // Operation running
  output logic write_unlock_latch_out, // Latch state
  output logic erase_strobe_out, // One-cycle erase order
  output logic [ADDR_W-1:0] erase_base_out, // Unit base address
  output logic [1:0] erase_span_out, // Unit size
  output logic prog_valid_out, // Program byte offered
  input wire logic prog_ready_in, // Array takes byte
  output logic [ADDR_W-1:0] prog_addr_out, // Byte address
  output logic [7:0] prog_data_out // Bits to clear to 0
);

  localparam int BW = $clog2(BLOCKS);
  localparam int FW = ADDR_W + 8;

  initial begin
    if (ADDR_W != BW + 16 || BLOCKS < 2 || WIPE_ALL_CYC < 1 || PAGE_WRITE_CYC < 1) begin
      $error("flash_erase_program: ADDR_W must equal log2(BLOCKS)+16");
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling and edge finding
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic sclk_prev_q, cs_prev_q;

  pin_sync #(.W(6), .RST_VAL(6'h10)) u_sync (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sync_out(pins_s),
    .pin_in({sclk_in, cs_n_in, sio_in}));

  wire sclk_s = pins_s[5];
  wire cs_n_s = pins_s[4];
  wire [3:0] sio_s = pins_s[3:0];
  wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_prev_q;
  wire cs_rise = cs_n_s & ~cs_prev_q;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [7:0] shift_q, opcode_q;
  logic [3:0] bits_q;
  logic [8:0] bytes_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] page_ptr_q;
  logic frame_ok_q;

  // Upper lines ignored in SPI mode
  wire [7:0] shift_d = qpi_mode_in ? {shift_q[3:0], sio_s} : {shift_q[6:0], sio_s[0]};
  wire [3:0] bits_d = bits_q + (qpi_mode_in ? 4'h4 : 4'h1);
  wire byte_done = sclk_rise & (bits_d == `BITS_PER_BYTE);
  wire data_byte = byte_done & (bytes_q >= `BYTES_ADDR_FRAME) & (opcode_q == `OPC_WRITE_PAGE);

  flash_seq_pkg::seq_state_e state_q;
  logic op_in_flight_q, latch_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      bits_q <= 4'h0;
      bytes_q <= 9'h000;
      addr_q <= '0;
      page_ptr_q <= 8'h00;
      frame_ok_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
      if (cs_fall) begin
        bits_q <= 4'h0;
        bytes_q <= 9'h000;
        frame_ok_q <= ~op_in_flight_q;
      end else if (sclk_rise) begin
        shift_q <= shift_d;
        bits_q <= byte_done ? 4'h0 : bits_d;
        if (byte_done && bytes_q != 9'h1FF) begin
          bytes_q <= bytes_q + 9'h001;
        end
        if (byte_done && frame_ok_q && bytes_q == 9'h000) begin
          opcode_q <= shift_d;
        end
        if (byte_done && frame_ok_q && bytes_q != 9'h000 && bytes_q < `BYTES_ADDR_FRAME) begin
          addr_q <= {addr_q[ADDR_W-9:0], shift_d};
        end
        if (byte_done && bytes_q == 9'h004) begin
          page_ptr_q <= shift_d;
        end else if (data_byte) begin
          page_ptr_q <= page_ptr_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Page buffer: a wrapping pointer keeps the newest 256 bytes
  // ----------------------------------------------------------------
  logic [7:0] page_mem [0:`PAGE_BYTES-1];
  logic [`PAGE_BYTES-1:0] page_vld_q;
  wire page_wr = data_byte & frame_ok_q & latch_q;

  always_ff @(posedge ref_clk_in) begin
    if (page_wr) begin
      page_mem[page_ptr_q] <= shift_d;
    end
  end

  // ----------------------------------------------------------------
  // Protection lookup for the framed address and the scan block
  // ----------------------------------------------------------------
  logic [BW-1:0] scan_q;
  wire [BW-1:0] blk = addr_q[ADDR_W-1:16];
  wire [16:0] rl_cnt = (range_lock_bits_in == 4'h0) ? 17'h0_0000 : (17'h0_0001 << (range_lock_bits_in - 4'h1));
  wire [16:0] blk_from_top = 17'(BLOCKS - 1) - 17'(blk);
  wire range_hit = (rl_cnt > blk_from_top);
  wire [15:0] edge_lock = (blk == '0) ? bottom_sector_lock_in :
                          (blk == BW'(BLOCKS - 1)) ? top_sector_lock_in : 16'h0000;
  wire is_4k = (opcode_q == `OPC_WIPE_4K) | (opcode_q == `OPC_WRITE_PAGE);
  wire [15:0] sec_one = 16'h0001 << addr_q[15:12];
  wire [15:0] sec_half = addr_q[15] ? 16'hFF00 : 16'h00FF;
  wire [15:0] span_mask = is_4k ? sec_one : (opcode_q == `OPC_WIPE_32K) ? sec_half : 16'hFFFF;
  wire unit_hit = persistent_unit_lock_in[blk] | volatile_unit_lock_in[blk] | ((edge_lock & span_mask) != 16'h0000);
  wire prot_hit = protect_scheme_select_in ? unit_hit : range_hit;
  wire scan_edge = (scan_q == '0) | (scan_q == BW'(BLOCKS - 1));
  wire scan_skip = persistent_unit_lock_in[scan_q] | volatile_unit_lock_in[scan_q] |
                   (scan_edge & ((scan_q == '0 ? bottom_sector_lock_in : top_sector_lock_in) != 16'h0000));

  // ----------------------------------------------------------------
  // Command acceptance at chip select rising
  // ----------------------------------------------------------------
  wire on_byte = (bits_q == 4'h0);
  wire is_erase = (opcode_q == `OPC_WIPE_4K) | (opcode_q == `OPC_WIPE_32K) | (opcode_q == `OPC_WIPE_64K);
  wire is_all = (opcode_q == `OPC_WIPE_ALL_A) | (opcode_q == `OPC_WIPE_ALL_B);
  wire is_page = (opcode_q == `OPC_WRITE_PAGE);
  wire take = cs_rise & frame_ok_q & on_byte & ~op_in_flight_q;
  wire unlock_go = take & (opcode_q == `OPC_WRITE_UNLOCK) & (bytes_q == `BYTES_OPCODE_ONLY);
  wire erase_go = take & latch_q & is_erase & (bytes_q == `BYTES_ADDR_FRAME) & ~prot_hit;
  wire all_go = take & latch_q & is_all & (bytes_q == `BYTES_OPCODE_ONLY) &
                (protect_scheme_select_in | (range_lock_bits_in == 4'h0));
  wire page_go = take & latch_q & is_page & (bytes_q >= `BYTES_PAGE_MIN) & ~prot_hit;
  wire start = erase_go | all_go | page_go;

  wire [31:0] erase_cyc = (opcode_q == `OPC_WIPE_4K) ? 32'(WIPE_4K_CYC) :
                          (opcode_q == `OPC_WIPE_32K) ? 32'(WIPE_32K_CYC) : 32'(WIPE_64K_CYC);
  wire [ADDR_W-1:0] unit_mask = (opcode_q == `OPC_WIPE_4K) ? {{(ADDR_W-12){1'b1}}, 12'h000} :
                                (opcode_q == `OPC_WIPE_32K) ? {{(ADDR_W-15){1'b1}}, 15'h0000} :
                                {{(ADDR_W-16){1'b1}}, 16'h0000};
  wire [1:0] erase_span = (opcode_q == `OPC_WIPE_4K) ? 2'(flash_seq_pkg::SPAN_4K) :
                          (opcode_q == `OPC_WIPE_32K) ? 2'(flash_seq_pkg::SPAN_32K) : 2'(flash_seq_pkg::SPAN_64K);

  // ----------------------------------------------------------------
  // Program byte stream into the FIFO
  // ----------------------------------------------------------------
  logic [8:0] push_idx_q;
  logic fifo_in_ready, fifo_empty;
  wire [7:0] push_lo = push_idx_q[7:0];
  wire push_valid = (state_q == flash_seq_pkg::ST_PUSH) & page_vld_q[push_lo];
  wire push_step = (state_q == flash_seq_pkg::ST_PUSH) & (~page_vld_q[push_lo] | fifo_in_ready);
  wire [FW-1:0] push_word = {addr_q[ADDR_W-1:8], push_lo, page_mem[push_lo]};

  prog_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .in_valid_in(push_valid), .in_ready_out(fifo_in_ready), .in_data_in(push_word), .out_valid_out(prog_valid_out),
    .out_ready_in(prog_ready_in), .out_data_out({prog_addr_out, prog_data_out}), .empty_out(fifo_empty));

  // ----------------------------------------------------------------
  // Sequencer: timer runs from start; finish waits for timer and drain
  // ----------------------------------------------------------------
  logic [31:0] timer_q;
  logic erase_strobe_q;
  logic [ADDR_W-1:0] erase_base_q;
  logic [1:0] erase_span_q;
  wire finish = (state_q == flash_seq_pkg::ST_RUN) & (timer_q == 32'h0000_0000) & fifo_empty;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= flash_seq_pkg::ST_IDLE;
      op_in_flight_q <= 1'b0;
      latch_q <= 1'b0;
      timer_q <= 32'h0000_0000;
      scan_q <= '0;
      push_idx_q <= 9'h000;
      page_vld_q <= '0;
      erase_strobe_q <= 1'b0;
      erase_base_q <= '0;
      erase_span_q <= 2'h0;
    end else begin
      erase_strobe_q <= 1'b0;
      if (timer_q != 32'h0000_0000) begin
        timer_q <= timer_q - 32'h0000_0001;
      end
      if (cs_fall && !op_in_flight_q) begin
        page_vld_q <= '0;
      end else if (page_wr) begin
        page_vld_q[page_ptr_q] <= 1'b1;
      end
      if (unlock_go) begin
        latch_q <= 1'b1;
      end
      case (state_q)
        flash_seq_pkg::ST_IDLE: begin
          if (erase_go) begin
            erase_strobe_q <= 1'b1;
            erase_base_q <= addr_q & unit_mask;
            erase_span_q <= erase_span;
            timer_q <= erase_cyc;
            state_q <= flash_seq_pkg::ST_RUN;
          end else if (all_go) begin
            scan_q <= '0;
            timer_q <= 32'(WIPE_ALL_CYC);
            state_q <= flash_seq_pkg::ST_SCAN;
          end else if (page_go) begin
            push_idx_q <= 9'h000;
            timer_q <= 32'(PAGE_WRITE_CYC);
            state_q <= flash_seq_pkg::ST_PUSH;
          end
          if (start) begin
            op_in_flight_q <= 1'b1;
          end
        end
        flash_seq_pkg::ST_SCAN: begin
          if (!scan_skip) begin
            erase_strobe_q <= 1'b1;
            erase_base_q <= {scan_q, 16'h0000};
            erase_span_q <= 2'(flash_seq_pkg::SPAN_64K);
          end
          scan_q <= scan_q + 1'b1;
          if (scan_q == BW'(BLOCKS - 1)) begin
            state_q <= flash_seq_pkg::ST_RUN;
          end
        end
        flash_seq_pkg::ST_PUSH: begin
          if (push_step) begin
            push_idx_q <= push_idx_q + 9'h001;
            if (push_idx_q == 9'h0FF) begin
              state_q <= flash_seq_pkg::ST_RUN;
            end
          end
        end
        flash_seq_pkg::ST_RUN: begin
          if (finish) begin
            op_in_flight_q <= 1'b0;
            latch_q <= 1'b0;
            state_q <= flash_seq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Status is live at all times, including mid-operation
  assign op_in_flight_flag_out = op_in_flight_q;
  assign write_unlock_latch_out = latch_q;
  assign erase_strobe_out = erase_strobe_q;
  assign erase_base_out = erase_base_q;
  assign erase_span_out = erase_span_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  chk_start_sets_flag: assert property (start |=> op_in_flight_q) else $error("busy flag not set after start");
  chk_done_clears_latch: assert property (finish |=> !op_in_flight_q && !latch_q)
    else $error("completion left flag or latch set");
  chk_start_needs_latch: assert property (start |-> latch_q) else $error("operation started without latch");
  chk_busy_blocks_start: assert property (op_in_flight_q |-> !start) else $error("started while busy");
  chk_erase_framing: assert property (erase_go |-> bytes_q == 9'h005 && bits_q == 4'h0)
    else $error("erase taken off the address boundary");
  chk_all_range_zero: assert property (all_go && !protect_scheme_select_in |-> range_lock_bits_in == 4'h0)
    else $error("whole erase taken with range lock set");
  chk_scan_skips_locked: assert property (state_q == flash_seq_pkg::ST_SCAN && scan_skip |=> !erase_strobe_q)
    else $error("locked block erased in scan");
  chk_page_framing: assert property (page_go |-> bytes_q >= 9'h006 && bits_q == 4'h0)
    else $error("page write taken off a byte boundary");
  chk_unit_aligned: assert property (erase_go |=> erase_strobe_q && (erase_base_q & ~unit_mask) == '0)
    else $error("erase base not aligned to unit");
  chk_locked_refused: assert property ((erase_go || page_go) |-> !prot_hit) else $error("locked unit taken");

endmodule

// [verification/host_link_model.sv]
// Host-side link model: drives select, serial clock and the four data pins.
// Assumes the core clock paces it; one serial clock period is 8 core clocks.
`timescale 1ns/100ps

module host_link_model (
  input wire logic ref_clk_in, // Core clock
  input wire logic qpi_in, // Four-line phases
  output logic sclk_out, // Serial clock, idle low
  output logic cs_n_out, // Select, low active
  output logic [3:0] sio_out // Data pins
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sio_out = 4'h5;
  end

  // One frame; drop trims units so select rises off a byte boundary
  task automatic frame(input logic [7:0] q[$], input int drop);
    int per;
    logic [7:0] b;
    @(posedge ref_clk_in);
    // Mode read after the edge, once a mode change from the bench has landed
    per = qpi_in ? 2 : 8;
    cs_n_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    for (int i = 0; i < q.size() * per - drop; i++) begin
      b = q[i / per];
      if (qpi_in) begin
        sio_out <= (i % 2 == 0) ? b[7:4] : b[3:0];
      end
      else begin
        sio_out <= {~sio_out[3:1], b[7 - i % 8]};
      end
      repeat (4) @(posedge ref_clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_in);
    cs_n_out <= 1'b1;
    // Released pins must not keep the last bit
    sio_out <= ~sio_out;
    repeat (8) @(posedge ref_clk_in);
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the erase and page-write sequencer.
// Assumes the host link model file and shortened operation durations.
`timescale 1ns/100ps

module tb_top;
  logic clk, rst, qpi, scheme, ready, sclk, cs_n, flag, latch, strobe, pvalid;
  logic [3:0] range_bits, sio;
  logic [511:0] pers_lock, vol_lock;
  logic [15:0] bot_lock, top_lock;
  logic [24:0] base, paddr, last_base, last_paddr;
  logic [1:0] span, last_span;
  logic [7:0] pdata;
  logic [7:0] pmem [256];
  logic [7:0] q[$];
  int errors, checks_done, n_erase, n_prog, cyc;

  // ----------------------------------------------------------------
  // Clock, parts and array-side monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Long 64K time keeps the block busy while a second frame arrives
  flash_erase_program #(.WIPE_4K_CYC(20), .WIPE_32K_CYC(20), .WIPE_64K_CYC(2000), .WIPE_ALL_CYC(20),
    .PAGE_WRITE_CYC(20)) flash_erase_program_i (.ref_clk_in(clk), .rst_in(rst), .sclk_in(sclk),
    .cs_n_in(cs_n), .sio_in(sio), .qpi_mode_in(qpi), .protect_scheme_select_in(scheme),
    .range_lock_bits_in(range_bits), .persistent_unit_lock_in(pers_lock), .volatile_unit_lock_in(vol_lock),
    .bottom_sector_lock_in(bot_lock), .top_sector_lock_in(top_lock), .op_in_flight_flag_out(flag),
    .write_unlock_latch_out(latch), .erase_strobe_out(strobe), .erase_base_out(base), .erase_span_out(span),
    .prog_valid_out(pvalid), .prog_ready_in(ready), .prog_addr_out(paddr), .prog_data_out(pdata));

  host_link_model host_link_model_i (.ref_clk_in(clk), .qpi_in(qpi), .sclk_out(sclk), .cs_n_out(cs_n),
    .sio_out(sio));

  // Array stalls half the time so the FIFO fills; every order is logged
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ready <= cyc[1];
    if (strobe === 1'b1) begin
      n_erase++;
      last_base = base;
      last_span = span;
    end
    if (pvalid === 1'b1 && ready === 1'b1) begin
      n_prog++;
      pmem[paddr[7:0]] = pdata;
      last_paddr = paddr;
    end
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for the running operation to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (flag !== 1'b0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    chk(k < 5000, 1);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end
    else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Second frame must be ignored; its select falls inside the running operation for all three erase sizes
  task automatic t_erase(input logic [7:0] opc, input logic [31:0] a, input logic [24:0] exp_b,
    input logic [1:0] sp);
    int e0;
    e0 = n_erase;
    host_link_model_i.frame({8'h06}, 0);
    chk(latch, 1);
    host_link_model_i.frame({opc, a[31:24], a[23:16], a[15:8], a[7:0]}, 0);
    chk(flag, 1);
    host_link_model_i.frame({opc, a[31:24], a[23:16], a[15:8], a[7:0]}, 0);
    wait_idle();
    chk(n_erase - e0, 1);
    chk(last_base, exp_b);
    chk(last_span, sp);
    chk(latch, 0);
    $display("test erase %h done", opc);
  endtask

  task automatic t_page();
    int p0;
    p0 = n_prog;
    host_link_model_i.frame({8'h06}, 0);
    host_link_model_i.frame({8'h02, 8'h00, 8'h00, 8'h01, 8'hFE, 8'hA5, 8'h3C, 8'h0F}, 0);
    wait_idle();
    chk(n_prog - p0, 3);
    chk({pmem[8'hFE], pmem[8'hFF], pmem[8'h00]}, 32'h00A5_3C0F);
    chk(last_paddr, 25'h000_01FF);
    chk(latch, 0);
    qpi <= 1'b1;
    p0 = n_prog;
    q = {8'h02, 8'h00, 8'h00, 8'h02, 8'h00};
    for (int i = 0; i < 258; i++) q.push_back(i[8:1]);
    host_link_model_i.frame({8'h06}, 0);
    host_link_model_i.frame(q, 0);
    wait_idle();
    chk(n_prog - p0, 256);
    chk({pmem[0], pmem[1], pmem[2]}, 32'h0080_8001);
    chk(last_paddr, 25'h000_02FF);
    qpi <= 1'b0;
    $display("test page done");
  endtask

  // Refusals first, then a whole erase that skips locked blocks 0, 3, 7
  task automatic t_protect();
    int e0, p0;
    e0 = n_erase;
    host_link_model_i.frame({8'h20, 8'h00, 8'h00, 8'h10, 8'h00}, 0);
    chk(flag, 0);
    host_link_model_i.frame({8'h06}, 0);
    host_link_model_i.frame({8'h20, 8'h00, 8'h00, 8'h10, 8'h00}, 1);
    chk(flag, 0);
    range_bits <= 4'h1;
    host_link_model_i.frame({8'hD8, 8'h01, 8'hFF, 8'h00, 8'h00}, 0);
    chk(flag, 0);
    host_link_model_i.frame({8'h60}, 0);
    chk(flag, 0);
    range_bits <= 4'h0;
    host_link_model_i.frame({8'h60, 8'h00}, 0);
    chk(flag, 0);
    scheme <= 1'b1;
    host_link_model_i.frame({8'hC7}, 0);
    chk(flag, 1);
    wait_idle();
    chk(n_erase - e0, 509);
    chk(latch, 0);
    p0 = n_prog;
    host_link_model_i.frame({8'h06}, 0);
    host_link_model_i.frame({8'h02, 8'h00, 8'h03, 8'h00, 8'h00, 8'h11}, 0);
    chk(flag, 0);
    chk(n_prog - p0, 0);
    $display("test protect done");
  endtask

  initial begin
    rst = 1'b1;
    {qpi, scheme, range_bits, top_lock, cyc, errors, checks_done, n_erase, n_prog} = '0;
    pers_lock = 512'h8;
    vol_lock = 512'h80;
    bot_lock = 16'h0004;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_erase(8'h20, 32'h0012_3456, 25'h012_3000, 2'h0);
    t_erase(8'h52, 32'h0012_BFFF, 25'h012_8000, 2'h1);
    qpi <= 1'b1;
    t_erase(8'hD8, 32'h0012_FFFF, 25'h012_0000, 2'h2);
    qpi <= 1'b0;
    t_page();
    t_protect();
    results();
  end
endmodule
